/* ptt_pkg.sv */
package ptt_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PERIOD   = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_DISP     = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Control field positions
  localparam int CTRL_ENABLE     = 0;
  localparam int CTRL_START_AL2  = 1;
  localparam int CTRL_ELAPSED    = 2;
  localparam int CTRL_SECONDS    = 3;
  localparam int CTRL_RESET_AL1  = 4;
  localparam int CTRL_SHOW_PER   = 5;
  localparam int CTRL_W          = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Period field positions
  localparam int PER_MINOR_LSB = 0;
  localparam int PER_MAJOR_LSB = 8;
  localparam int FLD_W         = 7;
  localparam logic [6:0] PER_MAJOR_RST = 7'h00;
  localparam logic [6:0] PER_MINOR_RST = 7'h00;

  // Status and display field positions
  localparam int STAT_RELAY   = 2;
  localparam int STAT_CNT_LSB = 16;
  localparam int DISP_GLYPH_LSB = 16;
  localparam int DISP_CCW       = 19;

  // Interrupt bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_START   = 1;
  localparam int IRQ_RESET   = 2;
  localparam int IRQ_W       = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Time limits
  localparam logic [6:0] MAJOR_MAX     = 7'h63;
  localparam logic [6:0] MINOR_MAX_MIN = 7'h3b;
  localparam logic [6:0] MINOR_MAX_SEC = 7'h63;
  localparam logic [6:0] RADIX_MIN     = 7'h3c;
  localparam logic [6:0] RADIX_SEC     = 7'h64;
  localparam int CNT_W = 14;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_MIN   = 60;

  typedef enum logic [1:0] {
    PTT_ST_RESET,
    PTT_ST_RUN,
    PTT_ST_DONE
  } ptt_state_t;

endpackage

/* ptt_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ptt_tick_gen #(
  parameter int unsigned CYC_PER_SEC = ptt_pkg::CYC_PER_SEC,
  parameter int unsigned SEC_PER_MIN = ptt_pkg::SEC_PER_MIN
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic sec_mode,
  output logic      tick_ff,
  output logic      sec_ff
);

  logic [31:0] cyc_ff;
  logic [7:0]  sec_cnt_ff;
  logic        sec_end;
  logic        min_end;

  assign sec_end = run && (cyc_ff == CYC_PER_SEC - 1);
  assign min_end = sec_end && (sec_cnt_ff == 8'(SEC_PER_MIN - 1));

  // Cycle prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 32'h0000_0000;
    end else if (clear || sec_end) begin
      cyc_ff <= 32'h0000_0000;
    end else if (run) begin
      cyc_ff <= cyc_ff + 32'h0000_0001;
    end
  end

  // Seconds within a minute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_ff <= 8'h00;
    end else if (clear || min_end) begin
      sec_cnt_ff <= 8'h00;
    end else if (sec_end) begin
      sec_cnt_ff <= sec_cnt_ff + 8'h01;
    end
  end

  // Unit tick and seconds pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
      sec_ff  <= 1'b0;
    end else begin
      tick_ff <= sec_mode ? sec_end : min_end;
      sec_ff  <= sec_end;
    end
  end

endmodule
`default_nettype wire

/* ptt_timer.sv */
// Notes on behaviour
// - Period runs from zero to 99:59 in hours:minutes or 99:99 in minutes:seconds.
// - Start comes from the run/hold key or the second alarm, as configured.
// - Display shows remaining time down with ccw glyph or elapsed time up with cw glyph.
// - Reset source is the key alone or the first alarm with the key; both reset, and the first alarm also starts.
// - While enabled the timer alone drives the first alarm relay.
// - At time-out the first alarm relay is driven and the glyph stops.
// - At time-out the display shows zero or the full period, as configured.
// - After time-out the timer waits until the key or the first alarm resets it.
// - Reset drops the relay and loads the display with the period.
// - In the reset state the up and down keys change the period, then a start is accepted.
// - A configurable increment selects whether the count advances by minutes or seconds.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ptt_timer #(
  parameter int unsigned CYC_PER_SEC = ptt_pkg::CYC_PER_SEC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  input  wire logic        run_hold_key,
  input  wire logic        inc_key,
  input  wire logic        dec_key,
  input  wire logic        first_alarm_source,
  input  wire logic        second_alarm_source,
  input  wire logic        other_alarm1_req,
  output logic             alarm1_relay_ff,
  output logic             irq_ff,
  output logic      [6:0]  disp_major_ff,
  output logic      [6:0]  disp_minor_ff,
  output logic      [2:0]  glyph_ff,
  output logic             glyph_ccw_ff
);

  localparam int CW = ptt_pkg::CNT_W;

  logic [ptt_pkg::CTRL_W-1:0] ctrl_ff;
  logic [6:0]            per_major_ff;
  logic [6:0]            per_minor_ff;
  logic [ptt_pkg::IRQ_W-1:0]  irq_stat_ff;
  logic [ptt_pkg::IRQ_W-1:0]  irq_mask_ff;
  logic [CW-1:0]         cnt_ff;
  ptt_pkg::ptt_state_t   state_ff;
  logic                  key_q_ff;
  logic                  inc_q_ff;
  logic                  dec_q_ff;
  logic                  al1_q_ff;
  logic                  al2_q_ff;

  logic          enable;
  logic          sec_mode;
  logic [6:0]    radix;
  logic [6:0]    minor_max;
  logic [CW-1:0] per_total;
  logic [CW-1:0] max_total;
  logic [CW-1:0] shown;
  logic          key_rise;
  logic          inc_rise;
  logic          dec_rise;
  logic          al1_rise;
  logic          al2_rise;
  logic          start_ev;
  logic          reset_ev;
  logic          timeout_ev;
  logic          tick;
  logic          sec_pulse;
  logic          wr_en;
  logic          rd_done;
  logic          addr_ok;
  logic [CW-1:0] nxt_per;
  logic          nxt_per_load;
  logic [ptt_pkg::IRQ_W-1:0] irq_set;

  function automatic logic [CW-1:0] to_units(input logic [6:0] maj,
                                             input logic [6:0] mnr,
                                             input logic [6:0] rdx);
    logic [CW-1:0] prod;
    prod = CW'(maj) * CW'(rdx);
    return prod + CW'(mnr);
  endfunction

  function automatic logic [6:0] clamp7(input logic [6:0] v,
                                        input logic [6:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  assign enable    = ctrl_ff[ptt_pkg::CTRL_ENABLE];
  assign sec_mode  = ctrl_ff[ptt_pkg::CTRL_SECONDS];
  assign radix     = sec_mode ? ptt_pkg::RADIX_SEC : ptt_pkg::RADIX_MIN;
  assign minor_max = sec_mode ? ptt_pkg::MINOR_MAX_SEC
                              : ptt_pkg::MINOR_MAX_MIN;
  assign per_total = to_units(per_major_ff, per_minor_ff, radix);
  assign max_total = to_units(ptt_pkg::MAJOR_MAX, minor_max, radix);

  // Input edges
  assign key_rise = run_hold_key && !key_q_ff;
  assign inc_rise = inc_key && !inc_q_ff;
  assign dec_rise = dec_key && !dec_q_ff;
  assign al1_rise = first_alarm_source && !al1_q_ff;
  assign al2_rise = second_alarm_source && !al2_q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q_ff <= 1'b0;
      inc_q_ff <= 1'b0;
      dec_q_ff <= 1'b0;
      al1_q_ff <= 1'b0;
      al2_q_ff <= 1'b0;
    end else begin
      key_q_ff <= run_hold_key;
      inc_q_ff <= inc_key;
      dec_q_ff <= dec_key;
      al1_q_ff <= first_alarm_source;
      al2_q_ff <= second_alarm_source;
    end
  end

  // Start and reset triggers
  assign start_ev = enable && (state_ff == ptt_pkg::PTT_ST_RESET) &&
    ((ctrl_ff[ptt_pkg::CTRL_START_AL2] ? al2_rise : key_rise) ||
     (ctrl_ff[ptt_pkg::CTRL_RESET_AL1] && al1_rise));
  assign reset_ev = enable && (state_ff != ptt_pkg::PTT_ST_RESET) &&
    (key_rise || (ctrl_ff[ptt_pkg::CTRL_RESET_AL1] && al1_rise));
  assign timeout_ev = (state_ff == ptt_pkg::PTT_ST_RUN) && !reset_ev &&
    (cnt_ff == per_total);

  ptt_tick_gen #(
    .CYC_PER_SEC (CYC_PER_SEC),
    .SEC_PER_MIN (ptt_pkg::SEC_PER_MIN)
  ) u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (start_ev),
    .run      (state_ff == ptt_pkg::PTT_ST_RUN),
    .sec_mode (sec_mode),
    .tick_ff  (tick),
    .sec_ff   (sec_pulse)
  );

  // Timer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ptt_pkg::PTT_ST_RESET;
    end else if (!enable) begin
      state_ff <= ptt_pkg::PTT_ST_RESET;
    end else begin
      unique case (state_ff)
        ptt_pkg::PTT_ST_RESET: begin
          if (start_ev) begin
            state_ff <= ptt_pkg::PTT_ST_RUN;
          end
        end
        ptt_pkg::PTT_ST_RUN: begin
          if (reset_ev) begin
            state_ff <= ptt_pkg::PTT_ST_RESET;
          end else if (timeout_ev) begin
            state_ff <= ptt_pkg::PTT_ST_DONE;
          end
        end
        ptt_pkg::PTT_ST_DONE: begin
          if (reset_ev) begin
            state_ff <= ptt_pkg::PTT_ST_RESET;
          end
        end
        default: begin
          state_ff <= ptt_pkg::PTT_ST_RESET;
        end
      endcase
    end
  end

  // Elapsed count in minor units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (state_ff != ptt_pkg::PTT_ST_RUN) begin
      cnt_ff <= '0;
    end else if (tick && cnt_ff != per_total) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  // Period adjust from the keypad
  always_comb begin
    nxt_per      = per_total;
    nxt_per_load = 1'b0;
    if (state_ff == ptt_pkg::PTT_ST_RESET) begin
      if (inc_rise && !dec_rise && per_total < max_total) begin
        nxt_per      = per_total + CW'(1);
        nxt_per_load = 1'b1;
      end else if (dec_rise && !inc_rise && per_total != '0) begin
        nxt_per      = per_total - CW'(1);
        nxt_per_load = 1'b1;
      end
    end
  end

  // APB handshake
  assign addr_ok = (paddr == ptt_pkg::ADDR_CTRL) ||
                   (paddr == ptt_pkg::ADDR_PERIOD) ||
                   (paddr == ptt_pkg::ADDR_STATUS) ||
                   (paddr == ptt_pkg::ADDR_DISP) ||
                   (paddr == ptt_pkg::ADDR_IRQ_STAT) ||
                   (paddr == ptt_pkg::ADDR_IRQ_MASK);
  assign wr_en   = psel && penable && pready_ff && pwrite;
  assign rd_done = psel && penable && pready_ff && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_ff <= 32'h0000_0000;
      unique case (paddr)
        ptt_pkg::ADDR_CTRL:     prdata_ff <= 32'(ctrl_ff);
        ptt_pkg::ADDR_PERIOD:   prdata_ff <=
          (32'(per_major_ff) << ptt_pkg::PER_MAJOR_LSB) |
          (32'(per_minor_ff) << ptt_pkg::PER_MINOR_LSB);
        ptt_pkg::ADDR_STATUS:   prdata_ff <=
          (32'(cnt_ff) << ptt_pkg::STAT_CNT_LSB) |
          (32'(alarm1_relay_ff) << ptt_pkg::STAT_RELAY) |
          32'(state_ff);
        ptt_pkg::ADDR_DISP:     prdata_ff <=
          (32'(glyph_ccw_ff) << ptt_pkg::DISP_CCW) |
          (32'(glyph_ff) << ptt_pkg::DISP_GLYPH_LSB) |
          (32'(disp_major_ff) << ptt_pkg::PER_MAJOR_LSB) |
          32'(disp_minor_ff);
        ptt_pkg::ADDR_IRQ_STAT: prdata_ff <= 32'(irq_stat_ff);
        ptt_pkg::ADDR_IRQ_MASK: prdata_ff <= 32'(irq_mask_ff);
        default:                prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= ptt_pkg::CTRL_RST;
      irq_mask_ff <= ptt_pkg::IRQ_MASK_RST;
    end else if (wr_en) begin
      if (paddr == ptt_pkg::ADDR_CTRL) begin
        ctrl_ff <= pwdata[ptt_pkg::CTRL_W-1:0];
      end
      if (paddr == ptt_pkg::ADDR_IRQ_MASK) begin
        irq_mask_ff <= pwdata[ptt_pkg::IRQ_W-1:0];
      end
    end
  end

  // Period register, limited to the valid range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_major_ff <= ptt_pkg::PER_MAJOR_RST;
      per_minor_ff <= ptt_pkg::PER_MINOR_RST;
    end else if (wr_en && paddr == ptt_pkg::ADDR_PERIOD) begin
      per_major_ff <= clamp7(pwdata[ptt_pkg::PER_MAJOR_LSB +: ptt_pkg::FLD_W],
                             ptt_pkg::MAJOR_MAX);
      per_minor_ff <= clamp7(pwdata[ptt_pkg::PER_MINOR_LSB +: ptt_pkg::FLD_W],
                             minor_max);
    end else if (nxt_per_load) begin
      per_major_ff <= 7'(nxt_per / CW'(radix));
      per_minor_ff <= 7'(nxt_per % CW'(radix));
    end else if (per_minor_ff > minor_max) begin
      per_minor_ff <= minor_max;
    end
  end

  // Sticky events, read clears, set wins
  assign irq_set = {reset_ev, start_ev, timeout_ev};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else if (rd_done && paddr == ptt_pkg::ADDR_IRQ_STAT) begin
      irq_stat_ff <= irq_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // First alarm relay ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm1_relay_ff <= 1'b0;
    end else if (enable) begin
      alarm1_relay_ff <= (state_ff == ptt_pkg::PTT_ST_DONE);
    end else begin
      alarm1_relay_ff <= other_alarm1_req;
    end
  end

  // Displayed value
  always_comb begin
    unique case (state_ff)
      ptt_pkg::PTT_ST_RUN: begin
        shown = ctrl_ff[ptt_pkg::CTRL_ELAPSED] ? cnt_ff
                                               : per_total - cnt_ff;
      end
      ptt_pkg::PTT_ST_DONE: begin
        shown = ctrl_ff[ptt_pkg::CTRL_SHOW_PER] ? per_total : '0;
      end
      default: begin
        shown = per_total;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_major_ff <= 7'h00;
      disp_minor_ff <= 7'h00;
    end else begin
      disp_major_ff <= 7'(shown / CW'(radix));
      disp_minor_ff <= 7'(shown % CW'(radix));
    end
  end

  // Rotating clock glyph
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glyph_ff     <= 3'h0;
      glyph_ccw_ff <= 1'b0;
    end else begin
      glyph_ccw_ff <= !ctrl_ff[ptt_pkg::CTRL_ELAPSED];
      if (state_ff == ptt_pkg::PTT_ST_RESET) begin
        glyph_ff <= 3'h0;
      end else if (state_ff == ptt_pkg::PTT_ST_RUN && sec_pulse) begin
        glyph_ff <= ctrl_ff[ptt_pkg::CTRL_ELAPSED] ? glyph_ff + 3'h1
                                                   : glyph_ff - 3'h1;
      end
    end
  end
  // Glyph holds still in the done state

endmodule
`default_nettype wire

/* ptt_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_chk #(
  parameter int unsigned CYC_PER_SEC = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  input wire logic        run_hold_key,
  input wire logic        inc_key,
  input wire logic        other_alarm1_req,
  input wire logic        alarm1_relay_ff,
  input wire logic        irq_ff,
  input wire logic [6:0]  disp_minor_ff,
  input wire logic [2:0]  glyph_ff,
  input wire logic        glyph_ccw_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup;
    psel && !penable;
  endsequence

  // Relay high with no other owner asking
  sequence by_timer;
    alarm1_relay_ff && !other_alarm1_req &&
    !$past(other_alarm1_req) && !$past(other_alarm1_req, 2);
  endsequence

  sequence glyph_held;
    ($stable(glyph_ff) || glyph_ff == 3'h0) [*8];
  endsequence

  pready_follow_a: assert property (apb_setup |=> pready_ff)
    else $error("pready missing after setup");
  pready_cause_a: assert property (
    pready_ff |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  slverr_ok_a: assert property (
    pslverr_ff |-> pready_ff && (pwrite || prdata_ff == 32'h0))
    else $error("bad error response");
  glyph_step_a: assert property (
    $changed(glyph_ff) && glyph_ff != 3'h0 |-> glyph_ff ==
    (glyph_ccw_ff ? $past(glyph_ff) - 3'h1 : $past(glyph_ff) + 3'h1))
    else $error("glyph step wrong");
  glyph_rate_a: assert property (
    $changed(glyph_ff) && glyph_ff != 3'h0 |=> glyph_held)
    else $error("glyph moves too fast");
  glyph_freeze_a: assert property (
    $rose(alarm1_relay_ff) ##0 by_timer |=> glyph_held)
    else $error("glyph moves after time-out");
  relay_drop_a: assert property (
    by_timer ##0 $rose(run_hold_key) |-> ##[1:2] !alarm1_relay_ff)
    else $error("relay kept after key reset");
  keys_ignored_a: assert property (
    by_timer ##0 $rose(inc_key) |=> $stable(disp_minor_ff) [*3])
    else $error("display changed after time-out");
  irq_hold_a: assert property (
    irq_ff && !psel && !$past(psel) |=> irq_ff)
    else $error("irq dropped without access");
endmodule

bind ptt_timer ptt_timer_chk #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .prdata_ff        (prdata_ff),
  .pready_ff        (pready_ff),
  .pslverr_ff       (pslverr_ff),
  .run_hold_key     (run_hold_key),
  .inc_key          (inc_key),
  .other_alarm1_req (other_alarm1_req),
  .alarm1_relay_ff  (alarm1_relay_ff),
  .irq_ff           (irq_ff),
  .disp_minor_ff    (disp_minor_ff),
  .glyph_ff         (glyph_ff),
  .glyph_ccw_ff     (glyph_ccw_ff)
);
`default_nettype wire

/* ptt_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module ptt_panel (
  input  wire logic pclk,
  output logic      run_hold_key,
  output logic      inc_key,
  output logic      dec_key,
  output logic      first_alarm_source,
  output logic      second_alarm_source,
  output logic      other_alarm1_req
);
  logic [4:0] ev_ff;
  logic       oth_ff;

  initial begin
    ev_ff  = 5'h00;
    oth_ff = 1'b0;
  end

  assign {second_alarm_source, first_alarm_source, dec_key, inc_key,
          run_hold_key} = ev_ff;
  assign other_alarm1_req = oth_ff;

  // Event 0 key, 1 up, 2 down, 3 first alarm, 4 second alarm
  task automatic press(input int k);
    @(posedge pclk);
    ev_ff[k] <= 1'b1;
    repeat (2) @(posedge pclk);
    ev_ff[k] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Other function asking for the relay
  task automatic other(input logic v);
    @(posedge pclk);
    oth_ff <= v;
  endtask
endmodule
`default_nettype wire

/* process_timeout_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module process_timeout_timer_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] q;
  logic        e;
  logic [2:0]  g;
  wire  [31:0] prdata_ff;
  wire         pready_ff, pslverr_ff, run_hold_key, inc_key, dec_key;
  wire         first_alarm_source, second_alarm_source, other_alarm1_req;
  wire         alarm1_relay_ff, irq_ff, glyph_ccw_ff;
  wire  [6:0]  disp_major_ff, disp_minor_ff;
  wire  [2:0]  glyph_ff;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0;

  ptt_timer #(.CYC_PER_SEC(10)) u_dut (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata_ff           (prdata_ff),
    .pready_ff           (pready_ff),
    .pslverr_ff          (pslverr_ff),
    .run_hold_key        (run_hold_key),
    .inc_key             (inc_key),
    .dec_key             (dec_key),
    .first_alarm_source  (first_alarm_source),
    .second_alarm_source (second_alarm_source),
    .other_alarm1_req    (other_alarm1_req),
    .alarm1_relay_ff     (alarm1_relay_ff),
    .irq_ff              (irq_ff),
    .disp_major_ff       (disp_major_ff),
    .disp_minor_ff       (disp_minor_ff),
    .glyph_ff            (glyph_ff),
    .glyph_ccw_ff        (glyph_ccw_ff)
  );
  ptt_panel u_pan (
    .pclk                (pclk),
    .run_hold_key        (run_hold_key),
    .inc_key             (inc_key),
    .dec_key             (dec_key),
    .first_alarm_source  (first_alarm_source),
    .second_alarm_source (second_alarm_source),
    .other_alarm1_req    (other_alarm1_req)
  );

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] v);
    n_compared++;
    if (v !== x) begin
      fails++;
      $display("FAIL %s expected %h seen %h", s, x, v);
    end
  endtask

  // One transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 50);
    chk("pready", 32'h1, 32'(pready_ff));
    q = prdata_ff;
    e = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string s);
    apb(1'b0, a, 32'h0);
    chk(s, x, q);
  endtask

  task automatic relay_wait(input int lim);
    for (int i = 0; i < lim && alarm1_relay_ff !== 1'b1; i++)
      @(posedge pclk);
  endtask

  task wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(ptt_pkg::ADDR_CTRL, 32'h0, "ctrl");
    rd(ptt_pkg::ADDR_PERIOD, 32'h0, "period");
    rd(ptt_pkg::ADDR_IRQ_MASK, 32'h0, "mask");
    rd(8'h18, 32'h0, "unmapped");
    chk("slverr", 32'h1, 32'(e));
    apb(1'b1, 8'h18, 32'h1);
    chk("slverr_w", 32'h1, 32'(e));
    $display("reset test done");
    apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h01);
    apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h7f7f);
    rd(ptt_pkg::ADDR_PERIOD, 32'h633b, "clamp_hm");
    apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h09);
    apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h7f7f);
    rd(ptt_pkg::ADDR_PERIOD, 32'h6363, "clamp_ms");
    u_pan.press(2);
    rd(ptt_pkg::ADDR_PERIOD, 32'h6362, "dec");
    chk("disp", 32'h62, 32'(disp_minor_ff));
    u_pan.press(1);
    u_pan.press(1);
    rd(ptt_pkg::ADDR_PERIOD, 32'h6363, "inc_sat");
    $display("period test done");
    apb(1'b1, ptt_pkg::ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h0003);
    t0 = cyc;
    u_pan.press(0);
    apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
    chk("run", 32'h1, 32'(q[1:0]));
    relay_wait(100);
    chk("span_s", 32'h1, 32'(cyc - t0 >= 25 && cyc - t0 <= 40));
    repeat (2) @(posedge pclk);
    chk("zero", 32'h0, 32'({disp_major_ff, disp_minor_ff}));
    chk("ccw", 32'h1, 32'(glyph_ccw_ff));
    chk("irq", 32'h1, 32'(irq_ff));
    g = glyph_ff;
    u_pan.press(1);
    repeat (10) @(posedge pclk);
    chk("frozen", 32'(g), 32'(glyph_ff));
    chk("hold", 32'h0, 32'(disp_minor_ff));
    apb(1'b0, ptt_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat", 32'h1, 32'(q[0]));
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, 32'(irq_ff));
    u_pan.press(0);
    chk("relay_off", 32'h0, 32'(alarm1_relay_ff));
    chk("reload", 32'h3, 32'({disp_major_ff, disp_minor_ff}));
    $display("remaining test done");
    apb(1'b1, ptt_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h3f);
    u_pan.press(4);
    repeat (10) @(posedge pclk);
    chk("up", 32'h1, 32'(disp_minor_ff));
    chk("cw", 32'h0, 32'(glyph_ccw_ff));
    relay_wait(60);
    repeat (2) @(posedge pclk);
    chk("full", 32'h3, 32'({disp_major_ff, disp_minor_ff}));
    chk("masked", 32'h0, 32'(irq_ff));
    apb(1'b0, ptt_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat2", 32'h1, 32'(q[0]));
    u_pan.press(3);
    chk("al1_rst", 32'h0, 32'(alarm1_relay_ff));
    u_pan.press(3);
    relay_wait(60);
    chk("al1_start", 32'h1, 32'(alarm1_relay_ff));
    u_pan.press(0);
    $display("elapsed test done");
    apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h01);
    apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h0001);
    t0 = cyc;
    u_pan.press(0);
    relay_wait(700);
    chk("span_m", 32'h1, 32'(cyc - t0 >= 595 && cyc - t0 <= 615));
    u_pan.press(0);
    $display("minute test done");
    u_pan.other(1'b1);
    repeat (3) @(posedge pclk);
    chk("owned", 32'h0, 32'(alarm1_relay_ff));
    apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h00);
    repeat (3) @(posedge pclk);
    chk("other", 32'h1, 32'(alarm1_relay_ff));
    u_pan.other(1'b0);
    $display("relay test done");
    wrap_up();
  end
endmodule
`default_nettype wire
